// [include/emb_framer_pkg.sv]
package emb_framer_pkg;

  // Register map, word aligned byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EMB_SIZE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CRC_LAST = 8'h0c;
  localparam logic [7:0] ADDR_SYNC_WORD = 8'h10;

  // Control field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MODE_64B66B_BIT = 1;
  localparam int CTRL_SCRAMBLE_8B10B_BIT = 2;
  localparam int CTRL_SYNC_REQ_OUT_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h2;

  // Status field positions
  localparam int STAT_BLOCK_IDX_LSB = 0;
  localparam int STAT_MB_IDX_LSB = 8;
  localparam int STAT_SYNC_IN_BIT = 16;
  localparam int STAT_SYSREF_SEEN_BIT = 17;
  localparam int STAT_SYNC_OUT_BIT = 18;

  // Multiblock geometry
  localparam int BLOCKS_PER_MB = 32;
  localparam int BLOCK_PAYLOAD_BITS = 64;
  localparam int BLOCK_BITS = 66;
  localparam int MB_BITS = BLOCKS_PER_MB * BLOCK_BITS;
  localparam int EMB_SIZE_MAX = 256;
  localparam logic [7:0] EMB_SIZE_RESET = 8'h01;

  // Sync header codes, bit 0 leaves first
  localparam logic [1:0] HDR_ONE = 2'h2;
  localparam logic [1:0] HDR_ZERO = 2'h1;
  localparam logic [1:0] HDR_NONE = 2'h0;

  // Sync word fixed content
  localparam logic [31:0] SYNC_FIXED_ONES = 32'h80a8_8888;
  localparam int SYNC_EXT_MULTIBLOCK_END_FLAG_BIT = 22;

  // Scrambler taps, polynomial 1 + x^39 + x^58
  localparam int SCR_LEN = 58;
  localparam int SCR_TAP_A = 38;
  localparam int SCR_TAP_B = 57;
  localparam logic [57:0] SCR_SEED = 58'h3ff_ffff_ffff_ffff;

  // Parity generator, x^12 + x^11 + x^3 + x^2 + x + 1
  localparam logic [11:0] CRC_POLY = 12'h80f;
  localparam logic [11:0] CRC_RESET = 12'h000;

  typedef struct packed {
    logic [1:0] header;
    logic [63:0] payload;
  } lane_block_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

endpackage : emb_framer_pkg

// [rtl/emb_framer.sv]
`timescale 1ns/1ps
// What this block does
// R1: Octet format same for both codings
// R2: 64b/66b always scrambled, 8b/10b optional
// R3: 8b/10b mode uses sync request pins
// R4: 64b/66b mode ignores sync request pins
// R5: Eight octets packed, D0 first
// R6: Scramble 64 bits, prepend clear header
// R7: Header 01 is one, 10 zero
// R8: 32 blocks form one sync word
// R9: Only 66-bit blocks, 2112-bit multiblock
// R10: E multiblocks per extended multiblock
// R11: E chosen as K times F over 256
// R12: SYSREF aligns extended multiblock counter
// R13: Sync word bit 0 sent first
// R14: Sync word gives sync, errors, latency
// R15: Command channel bits always zero
// R16: CRC bits placed in sync word nibbles
// R17: Bit 22 marks last multiblock
// R18: Fixed ones and 00001 pilot
// R19: CRC over scrambled bits, sent next
// R20: Link starts itself, no sync request
// R21: Receiver rejects invalid headers; the far-end model only counts them in o_bad
module emb_framer #(
  parameter int BLOCK_IDX_W = 5,
  parameter int MB_IDX_W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire emb_framer_pkg::reg_req_type i_reg_req,
  output logic [31:0] o_reg_rdata,
  input wire logic [63:0] i_octets,
  input wire logic i_octets_valid,
  input wire logic i_sysref_input_p,
  input wire logic i_sync_request_in_pins_n,
  output emb_framer_pkg::lane_block_type o_block,
  output logic o_block_valid,
  output logic o_multiblock_start,
  output logic o_sync_request_out_pins_n
);
  import emb_framer_pkg::*;

  // Elaboration checks; one sync word bit per block, so the
  // block index must cover exactly one multiblock
  if (BLOCK_IDX_W != $clog2(BLOCKS_PER_MB)) begin : g_block_idx_w_check
    $error("BLOCK_IDX_W must index exactly one multiblock");
  end
  // Status shows eight bits of multiblock index; E up to 255 must fit
  if (MB_IDX_W < 8) begin : g_mb_idx_w_check
    $error("MB_IDX_W must hold the extended multiblock size");
  end
  // One transition bit per block has to fill the 32-bit sync word
  if (BLOCKS_PER_MB != 32) begin : g_sync_word_check
    $error("BLOCKS_PER_MB must match the sync word width");
  end

  // Scrambler, one 64-bit block at a time, bit 0 first
  // Result: next state in the top 58 bits, scrambled word below
  function automatic logic [121:0] scramble_block(
    input logic [57:0] st,
    input logic [63:0] d
  );
    logic [57:0] s;
    logic [63:0] q;
    s = st;
    q = '0;
    for (int i = 0; i < BLOCK_PAYLOAD_BITS; i++) begin
      q[i] = d[i] ^ s[SCR_TAP_A] ^ s[SCR_TAP_B];
      s = {s[56:0], q[i]};
    end
    return {s, q};
  endfunction : scramble_block

  // Parity over one scrambled block, same bit order as the lane
  // Shifted bit 0 first so the running value matches a serial checker
  function automatic logic [11:0] crc_block(
    input logic [11:0] c_in,
    input logic [63:0] d
  );
    logic [11:0] c;
    logic fb;
    c = c_in;
    fb = 1'b0;
    for (int i = 0; i < BLOCK_PAYLOAD_BITS; i++) begin
      fb = c[11] ^ d[i];
      c = {c[10:0], 1'b0} ^ ({12{fb}} & CRC_POLY);
    end
    return c;
  endfunction : crc_block

  // Control and configuration state
  // Written only over the register port
  logic [3:0] ctrl_q;
  logic [7:0] emb_size_q;
  logic [31:0] rdata_q;

  // SYSREF and sync request synchronisers
  logic sysref_meta_q;
  logic sysref_sync_q;
  logic sysref_prev_q;
  logic sysref_seen_q;
  logic sync_in_meta_q;
  logic sync_in_sync_q;

  // Framing counters
  // Block index wraps by itself at the end of a multiblock
  logic [BLOCK_IDX_W-1:0] block_idx_q;
  logic [MB_IDX_W-1:0] mb_idx_q;

  // Data path state
  // Scrambler, parity and the registered lane block
  logic [57:0] scr_state_q;
  logic [11:0] crc_acc_q;
  logic [11:0] crc_last_q;
  lane_block_type block_q;
  logic block_valid_q;
  logic mb_start_q;
  logic sync_out_n_q;

  // Combinational terms
  logic enable;
  logic mode_64b66b;
  logic scramble_on;
  logic sysref_rise;
  logic step;
  logic last_block;
  logic last_mb;
  logic [MB_IDX_W-1:0] emb_last_idx;
  logic [31:0] sync_word;
  logic [121:0] scr_result;
  logic [63:0] payload_scr;
  logic [11:0] crc_next;
  logic sync_bit;

  assign enable = ctrl_q[CTRL_ENABLE_BIT];
  assign mode_64b66b = ctrl_q[CTRL_MODE_64B66B_BIT];

  // R2: scrambling forced in 64b/66b
  assign scramble_on = mode_64b66b | ctrl_q[CTRL_SCRAMBLE_8B10B_BIT];

  // R20: runs as soon as enabled, no request needed
  // Nothing waits on the far end; the lane starts on its own
  assign step = enable & i_octets_valid;

  // R8: 32 blocks per multiblock
  assign last_block = (block_idx_q == BLOCK_IDX_W'(BLOCKS_PER_MB - 1));

  // Final multiblock index; a size of zero behaves as one
  assign emb_last_idx = (emb_size_q == 8'h00) ? '0 : MB_IDX_W'(emb_size_q - 8'h01);
  // R10: E multiblocks per extended multiblock
  assign last_mb = (mb_idx_q >= emb_last_idx);

  // Edge of the synchronised reference level
  assign sysref_rise = sysref_sync_q & ~sysref_prev_q;

  // R5: D0 in the low octet, sent first
  assign scr_result = scramble_block(scr_state_q, i_octets);
  // R6: whole block scrambled, header added after
  assign payload_scr = scramble_on ? scr_result[63:0] : i_octets;
  // R19: parity over scrambled payload only
  assign crc_next = crc_block(crc_acc_q, payload_scr);

  // Sync word assembly for the running multiblock
  always_comb begin
    sync_word = SYNC_FIXED_ONES;
    // R16: CRC of previous multiblock, three bits per nibble
    sync_word[0] = crc_last_q[11];
    sync_word[1] = crc_last_q[10];
    sync_word[2] = crc_last_q[9];
    sync_word[4] = crc_last_q[8];
    sync_word[5] = crc_last_q[7];
    sync_word[6] = crc_last_q[6];
    sync_word[8] = crc_last_q[5];
    sync_word[9] = crc_last_q[4];
    sync_word[10] = crc_last_q[3];
    sync_word[12] = crc_last_q[2];
    sync_word[13] = crc_last_q[1];
    sync_word[14] = crc_last_q[0];
    // R17: end of extended multiblock flag
    sync_word[SYNC_EXT_MULTIBLOCK_END_FLAG_BIT] = last_mb;
    // R15: command channel left at zero by the constant
    // Positions 16 to 18, 20 and 24 to 26 are never set
    // R18: fixed ones and pilot come from the constant
    // Ones at 3, 7, 11, 15, 19, 21, 23 and 31; zeros 27 to 30
  end

  // R13: bit 0 rides on block 0
  // Block index selects the transition bit of the sync word
  assign sync_bit = sync_word[block_idx_q];

  // Register writes
  // Unmapped writes fall through and leave every field as it was
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= CTRL_RESET;
      emb_size_q <= EMB_SIZE_RESET;
    end else if (i_reg_req.wr) begin
      case (i_reg_req.addr)
        ADDR_CTRL: begin
          ctrl_q <= i_reg_req.wdata[3:0];
        end
        // R11: software loads E computed from K and F
        ADDR_EMB_SIZE: begin
          emb_size_q <= i_reg_req.wdata[7:0];
        end
        default: begin
          ctrl_q <= ctrl_q;
        end
      endcase
    end
  end

  // Register reads, data one cycle after the strobe, unmapped reads zero
  // Zero outside the answer cycle keeps the read bus quiet
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_reg_req.rd) begin
      rdata_q <= 32'h0000_0000;
      case (i_reg_req.addr)
        ADDR_CTRL: begin
          rdata_q[3:0] <= ctrl_q;
        end
        ADDR_EMB_SIZE: begin
          rdata_q[7:0] <= emb_size_q;
        end
        // Live counters and pin levels for bring-up
        ADDR_STATUS: begin
          rdata_q[STAT_BLOCK_IDX_LSB +: BLOCK_IDX_W] <= block_idx_q;
          rdata_q[STAT_MB_IDX_LSB +: 8] <= mb_idx_q[7:0];
          rdata_q[STAT_SYNC_IN_BIT] <= sync_in_sync_q;
          rdata_q[STAT_SYSREF_SEEN_BIT] <= sysref_seen_q;
          rdata_q[STAT_SYNC_OUT_BIT] <= sync_out_n_q;
        end
        ADDR_CRC_LAST: begin
          rdata_q[11:0] <= crc_last_q;
        end
        // R14: current sync word visible for debug
        ADDR_SYNC_WORD: begin
          rdata_q <= sync_word;
        end
        default: begin
          rdata_q <= 32'h0000_0000;
        end
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // Pin synchronisers, first stage feeds only the second
  // Request input idles high, so no false request after reset
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sysref_meta_q <= 1'b0;
      sysref_sync_q <= 1'b0;
      sysref_prev_q <= 1'b0;
      sync_in_meta_q <= 1'b1;
      sync_in_sync_q <= 1'b1;
    end else begin
      sysref_meta_q <= i_sysref_input_p;
      sysref_sync_q <= sysref_meta_q;
      sysref_prev_q <= sysref_sync_q;
      sync_in_meta_q <= i_sync_request_in_pins_n;
      sync_in_sync_q <= sync_in_meta_q;
    end
  end

  // Sticky SYSREF seen flag; cleared by any control write
  // A rising edge in the clearing cycle wins over the clear
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sysref_seen_q <= 1'b0;
    end else if (sysref_rise) begin
      sysref_seen_q <= 1'b1;
    end else if (i_reg_req.wr && i_reg_req.addr == ADDR_CTRL) begin
      sysref_seen_q <= 1'b0;
    end
  end

  // Extended multiblock counter
  // Held at zero while disabled, so enabling starts at block 0
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      block_idx_q <= '0;
      mb_idx_q <= '0;
    end else if (sysref_rise || !enable) begin
      // R12: SYSREF edge restarts the counter at once, even mid multiblock
      block_idx_q <= '0;
      mb_idx_q <= '0;
    end else if (step) begin
      block_idx_q <= block_idx_q + 1'b1;
      if (last_block) begin
        mb_idx_q <= last_mb ? '0 : mb_idx_q + 1'b1;
      end
    end
  end

  // Scrambler runs free across blocks; self-synchronising at the far end
  // Not restarted on alignment: the far end needs no shared seed
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scr_state_q <= SCR_SEED;
    end else if (step && scramble_on) begin
      scr_state_q <= scr_result[121:64];
    end
  end

  // Parity accumulates per multiblock and is handed to the next one
  // Alignment drops a partial sum; the last full result is kept
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      crc_acc_q <= CRC_RESET;
      crc_last_q <= CRC_RESET;
    end else if (sysref_rise || !enable) begin
      crc_acc_q <= CRC_RESET;
    end else if (step) begin
      // R19: result goes out in the following multiblock
      if (last_block) begin
        crc_last_q <= crc_next;
        crc_acc_q <= CRC_RESET;
      end else begin
        crc_acc_q <= crc_next;
      end
    end
  end

  // Lane block output, one 66-bit block per accepted word
  // Block holds between accepted words; valid marks each new one
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      block_q <= '0;
      block_valid_q <= 1'b0;
      mb_start_q <= 1'b0;
    end else begin
      block_valid_q <= step;
      mb_start_q <= step && (block_idx_q == '0);
      if (step) begin
        // R1: octet layout unchanged by coding choice
        block_q.payload <= payload_scr;
        if (mode_64b66b) begin
          // R7: one transition per header, never 00 or 11
          // R9: fixed 66-bit block, no 80-bit variant
          block_q.header <= sync_bit ? HDR_ONE : HDR_ZERO;
        end else begin
          // R3: 8b/10b carries no header; encoder lives downstream
          block_q.header <= HDR_NONE;
        end
      end
    end
  end

  // Sync request output pin
  // Active low, so reset leaves it deasserted
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_out_n_q <= 1'b1;
    end else if (mode_64b66b) begin
      // R4: pin idles deasserted, input ignored
      sync_out_n_q <= 1'b1;
    end else begin
      // R3: software drives the request in 8b/10b mode
      sync_out_n_q <= ~ctrl_q[CTRL_SYNC_REQ_OUT_BIT];
    end
  end

  // Outputs straight from registers
  assign o_reg_rdata = rdata_q;
  assign o_block = block_q;
  assign o_block_valid = block_valid_q;
  assign o_multiblock_start = mb_start_q;
  assign o_sync_request_out_pins_n = sync_out_n_q;

endmodule : emb_framer

// [tb/emb_far_end.sv]
`timescale 1ns/1ps
module emb_far_end
  import emb_framer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire emb_framer_pkg::lane_block_type i_blk,
  input wire logic i_vld,
  input wire logic i_start,
  input wire logic i_descr,
  output logic [31:0] o_word,
  output logic o_word_stb,
  output logic [63:0] o_data,
  output logic o_data_stb,
  output logic [7:0] o_bad
);
  logic [31:0] acc_q;
  logic [5:0] idx_q;
  logic [57:0] hist_q;
  // Lane receiver; self-synchronising, so no seed is shared
  always_ff @(posedge i_clk or negedge i_rst_n) begin : rx
    logic [57:0] h;
    logic [63:0] d;
    logic [31:0] w;
    logic [5:0] ix;
    if (!i_rst_n) begin
      acc_q <= '0;
      idx_q <= '0;
      hist_q <= '0;
      o_word <= '0;
      o_word_stb <= 1'b0;
      o_data <= '0;
      o_data_stb <= 1'b0;
      o_bad <= '0;
    end else begin
      o_word_stb <= 1'b0;
      o_data_stb <= i_vld;
      if (i_vld) begin
        h = hist_q;
        for (int k = 0; k < 64; k++) begin
          d[k] = i_blk.payload[k] ^ (i_descr & (h[SCR_TAP_A] ^ h[SCR_TAP_B]));
          h = {h[56:0], i_blk.payload[k]};
        end
        hist_q <= h;
        o_data <= d;
        // second header bit, bit 0 first
        w = i_start ? 32'h0000_0000 : acc_q;
        ix = i_start ? 6'h00 : idx_q;
        w[ix[4:0]] = i_blk.header[1];
        acc_q <= w;
        idx_q <= ix + 6'h01;
        if (ix == 6'h1f) begin
          o_word <= w;
          o_word_stb <= 1'b1;
        end
        if (i_descr && (i_blk.header[0] == i_blk.header[1])) begin
          o_bad <= o_bad + 8'h01;
        end
      end
    end
  end
endmodule : emb_far_end

// [tb/emb_framer_properties.sv]
`timescale 1ns/1ps
module emb_framer_properties
  import emb_framer_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire emb_framer_pkg::reg_req_type i_reg_req,
  input wire logic i_octets_valid,
  input wire emb_framer_pkg::lane_block_type o_block,
  input wire logic o_block_valid,
  input wire logic o_multiblock_start,
  input wire logic o_sync_request_out_pins_n
);
  logic mode_q;
  logic e1_q;
  logic seen_q;
  logic [5:0] idx_q;
  logic wc;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // Shadow of mode and extended multiblock size
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q <= 1'b1;
      e1_q <= 1'b1;
    end else if (i_reg_req.wr && i_reg_req.addr == ADDR_CTRL) begin
      mode_q <= i_reg_req.wdata[CTRL_MODE_64B66B_BIT];
    end else if (i_reg_req.wr && i_reg_req.addr == ADDR_EMB_SIZE) begin
      e1_q <= (i_reg_req.wdata[7:1] == 7'h00);
    end
  end
  // Block position in its sync word; SYSREF shows as an early start
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idx_q <= 6'h00;
      seen_q <= 1'b0;
    end else if (o_multiblock_start) begin
      idx_q <= 6'h01;
      seen_q <= 1'b1;
    end else if (o_block_valid) begin
      idx_q <= idx_q + 6'h01;
    end
  end
  assign wc = seen_q && o_block_valid && !o_multiblock_start && mode_q;
  property p_cause; o_block_valid |-> $past(i_octets_valid); endproperty
  a_cause: assert property (p_cause) else $error("block without word");
  property p_hdr; o_block_valid && mode_q && $past(mode_q) |-> o_block.header[0] != o_block.header[1]; endproperty
  a_hdr: assert property (p_hdr) else $error("invalid header");
  property p_ones; wc && idx_q inside {3, 7, 11, 15, 19, 21, 23, 31} |-> o_block.header == HDR_ONE; endproperty
  a_ones: assert property (p_ones) else $error("fixed one missing");
  property p_cmd; wc && idx_q inside {16, 17, 18, 20, 24, 25, 26} |-> o_block.header == HDR_ZERO; endproperty
  a_cmd: assert property (p_cmd) else $error("command bit set");
  property p_pilot; wc && idx_q inside {27, 28, 29, 30} |-> o_block.header == HDR_ZERO; endproperty
  a_pilot: assert property (p_pilot) else $error("pilot wrong");
  property p_ext_multiblock_end_flag; wc && e1_q && idx_q == 6'h16 |-> o_block.header == HDR_ONE; endproperty
  a_ext_multiblock_end_flag: assert property (p_ext_multiblock_end_flag) else $error("end flag missing");
  property p_mblen; seen_q && o_block_valid && idx_q == 6'h20 |-> o_multiblock_start; endproperty
  a_mblen: assert property (p_mblen) else $error("multiblock not 32");
  property p_soff; mode_q && $past(mode_q) |-> o_sync_request_out_pins_n; endproperty
  a_soff: assert property (p_soff) else $error("request pin used");
  c_start: cover property (o_multiblock_start);
  c_emb2: cover property (wc && !e1_q && idx_q == 6'h16);
  c_clear: cover property (!mode_q && o_block_valid);
endmodule : emb_framer_properties

bind emb_framer emb_framer_properties emb_framer_properties_inst (
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_reg_req(i_reg_req),
  .i_octets_valid(i_octets_valid), .o_block(o_block), .o_block_valid(o_block_valid),
  .o_multiblock_start(o_multiblock_start),
  .o_sync_request_out_pins_n(o_sync_request_out_pins_n)
);

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  import emb_framer_pkg::*;
  logic clk, rst_n, ov, sref, sin_n, descr, skip, bvld, mbs, sout_n, wstb, dstb;
  reg_req_type req;
  lane_block_type blk;
  logic [63:0] oct, data, q[$];
  logic [31:0] rdata, word, bn, v, w;
  logic [7:0] bad;
  logic [11:0] crc_run, crc_prev;
  int n_errors, total_checks;
  emb_framer emb_framer_inst (.i_sys_clk(clk), .i_arst_n(rst_n), .i_reg_req(req),
    .o_reg_rdata(rdata), .i_octets(oct), .i_octets_valid(ov), .i_sysref_input_p(sref),
    .i_sync_request_in_pins_n(sin_n), .o_block(blk), .o_block_valid(bvld),
    .o_multiblock_start(mbs), .o_sync_request_out_pins_n(sout_n));
  emb_far_end emb_far_end_inst (.i_clk(clk), .i_rst_n(rst_n), .i_blk(blk), .i_vld(bvld),
    .i_start(mbs), .i_descr(descr), .o_word(word), .o_word_stb(wstb), .o_data(data),
    .o_data_stb(dstb), .o_bad(bad));
  always #50 clk = ~clk;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd
  // Back-to-back blocks; expected octets queued for the far end
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      oct <= {bn, ~bn} ^ 64'h0123_4567_89ab_cdef;
      q.push_back({bn, ~bn} ^ 64'h0123_4567_89ab_cdef);
      ov <= 1'b1;
      bn = bn + 32'h0000_0001;
    end
    @(posedge clk);
    ov <= 1'b0;
  endtask : send
  task automatic get_word();
    for (int k = 0; k < 8 && !wstb; k++) begin
      @(posedge clk);
      #1;
    end
    if (wstb) begin
      w = word;
    end else begin
      n_errors++;
      conclude();
    end
  endtask : get_word
  // Pulse outlasts the two-stage synchroniser
  task automatic sync_ref();
    @(posedge clk);
    sref <= 1'b1;
    repeat (4) @(posedge clk);
    sref <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : sync_ref
  // CRC bits 11:9, 8:6, 5:3, 2:0 beside the fixed ones
  function automatic logic [31:0] spread(input logic [11:0] c);
    spread = 32'h80e8_8888;
    for (int k = 0; k < 12; k++) begin
      spread[(k / 3) * 4 + k % 3] = c[11 - k];
    end
  endfunction : spread
  // reference parity over the received scrambled payload, one multiblock behind
  always @(posedge clk) begin
    if (bvld) begin
      if (mbs) begin
        crc_prev = crc_run;
        crc_run = 12'h000;
      end
      for (int k = 0; k < 64; k++) begin
        crc_run = {crc_run[10:0], 1'b0} ^ ({12{crc_run[11] ^ blk.payload[k]}} & CRC_POLY);
      end
    end
  end
  // recovered octets; first block skipped while descrambler fills
  always @(posedge clk) begin
    if (dstb) begin
      if (!skip) check(data, q[0]);
      skip <= 1'b0;
      void'(q.pop_front());
    end
  end
  initial begin
    {clk, rst_n, ov, sref, req, oct, crc_run, crc_prev} = '0;
    {sin_n, descr, skip} = 3'b111;
    bn = 32'h0000_0000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL);
    check(v, 32'h0000_0002);
    rd(ADDR_EMB_SIZE);
    check(v, 32'h0000_0001);
    rd(8'h14);
    check(v, 32'h0000_0000);
    // idle sync word: fixed ones, end flag, no parity yet
    rd(ADDR_SYNC_WORD);
    check(v, 32'h80e8_8888);
    wr(ADDR_CTRL, 32'h0000_000b);
    sync_ref();
    check(sout_n, 1'b1);
    rd(ADDR_STATUS);
    check(v[STAT_SYSREF_SEEN_BIT], 1'b1);
    send(32);
    get_word();
    check(w & 32'hffff_8888, 32'h80e8_8888);
    send(16);
    rd(ADDR_CRC_LAST);
    check(v[11:0], crc_prev);
    send(16);
    get_word();
    check(w, spread(crc_prev));
    wr(ADDR_EMB_SIZE, 32'h0000_0002);
    sync_ref();
    send(32);
    get_word();
    check(w[22], 1'b0);
    send(32);
    get_word();
    check(w[22], 1'b1);
    // SYSREF mid multiblock restarts at block 0
    send(10);
    sync_ref();
    send(1);
    #1;
    check(mbs, 1'b1);
    // clear 8b/10b path uses request pins
    wr(ADDR_CTRL, 32'h0000_0009);
    descr <= 1'b0;
    sin_n <= 1'b0;
    repeat (4) @(posedge clk);
    check(sout_n, 1'b0);
    rd(ADDR_STATUS);
    check(v[STAT_SYNC_IN_BIT], 1'b0);
    send(3);
    repeat (4) @(posedge clk);
    check(bad, 8'h00);
    conclude();
  end
endmodule : tb
